// [dv/ppp_port_properties.sv]
// Pin-mode checks on the PROM port.
// Assumes pins held steady between changes, clk_en high.
`default_nettype none
module ppp_port_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic chip_reset_pin_n,
	input wire logic ce_pin_n,
	input wire logic oe_pin_n,
	input wire logic vpp_pin,
	input wire logic data_pin_oe,
	input wire logic prom_mode,
	input wire logic prog_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] p1, p2, p3;
	wire st = p2 == p3;
	always_ff @(posedge clk_sys) begin
		p1 <= rst_n ? {chip_reset_pin_n, ce_pin_n, oe_pin_n, vpp_pin} : 4'he;
		p2 <= rst_n ? p1 : 4'he;
		p3 <= rst_n ? p2 : 4'he;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_MODE: assert property (st |-> prom_mode == !p3[3]) else $error("mode");
	AST_READ: assert property (st && p3 == 4'h0 |-> data_pin_oe) else $error("read");
	AST_ODIS: assert property (st && p3 == 4'h2 |-> !data_pin_oe) else $error("odis");
	AST_PROG: assert property (st && p3 == 4'h3 |-> !data_pin_oe) else $error("prog");
	AST_VERIFY: assert property (st && p3 == 4'h5 |-> data_pin_oe) else $error("verify");
	AST_PDIS: assert property (st && p3 == 4'h7 |-> !data_pin_oe && !prog_busy) else $error("pdis");
	AST_WSTART: assert property (prog_busy |-> p3 == 4'h3) else $error("wstart");
	AST_WONCE: assert property (prog_busy |=> !prog_busy [*2]) else $error("wonce");
	C_PROG: cover property (prog_busy);
	C_READ: cover property (p3 == 4'h0 && data_pin_oe);
	C_VER: cover property (p3 == 4'h5 && data_pin_oe);
endmodule : ppp_port_checker
bind ppp_port ppp_port_checker u_chk (.clk_sys, .rst_n, .chip_reset_pin_n, .ce_pin_n, .oe_pin_n, .vpp_pin,
	.data_pin_oe, .prom_mode, .prog_busy);
`default_nettype wire

// [dv/ppp_prog_model.sv]
// Programmer side of the shared data pins.
// Assumes one clock; released pins show a pattern changing each cycle.
`default_nettype none
module ppp_prog_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] dev_o,
	input  wire logic       dev_oe,
	input  wire logic [7:0] drv,
	input  wire logic       drv_en,
	output var  logic [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last = 8'h00;
	assign pin = dev_oe ? dev_o : drv_en ? drv : ~last;
	always @(posedge clk_sys) last <= pin;
endmodule : ppp_prog_model
`default_nettype wire

// [dv/testbench.sv]
// Bench: programs, verifies and reads back bytes.
// Assumes the bound checker and the programmer model.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ppp_pkg::*;
	logic clk_sys = 0, rst_n = 0, rp_n = 1, ce_n = 1, oe_n = 1, vpp = 0, pen = 0, look = 0, oe, pm, busy;
	logic [14:0] adr = 0;
	logic [7:0] pd = 0, di, dq, a, b;
	logic [7:0] q[$];
	int bad_count = 0, samples_checked = 0;
	int writes_seen = 0;
	ppp_port dut (.clk_sys, .rst_n, .clk_en(1'b1), .chip_reset_pin_n(rp_n), .ce_pin_n(ce_n), .oe_pin_n(oe_n),
		.vpp_pin(vpp), .addr_pin(adr), .data_pin_i(di), .data_pin_o(dq), .data_pin_oe(oe), .prom_mode(pm),
		.prog_busy(busy));
	ppp_prog_model pgm (.clk_sys, .dev_o(dq), .dev_oe(oe), .drv(pd), .drv_en(pen), .pin(di));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic pins(input logic c, o, v);
		@(posedge clk_sys);
		ce_n <= c;
		oe_n <= o;
		vpp <= v;
		repeat (5) @(posedge clk_sys);
	endtask : pins
	task automatic cmp(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (e !== g) begin
			bad_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] d);
		pd <= d;
		pen <= 1;
		pins(1'b1, 1'b1, 1'b1);
		pins(1'b0, 1'b1, 1'b1);
		pins(1'b1, 1'b1, 1'b1);
	endtask : wr
	task automatic rd(input logic c, v, input logic [7:0] e);
		pen <= 0;
		pins(c, 1'b0, v);
		q.push_back(e);
		look <= 1;
		@(posedge clk_sys);
		look <= 0;
	endtask : rd
	task automatic final_report;
		$display("Checked %0d, errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	always @(posedge clk_sys) if (look) begin
		cmp("drive", 8'h01, {7'h0, oe});
		cmp("data", q.pop_front(), dq);
	end
	always @(posedge clk_sys) if (busy) writes_seen++;
	initial begin
		#50us;
		bad_count++;
		final_report();
	end
	initial begin
		void'($urandom(32'he108));
		repeat (6) @(posedge clk_sys);
		rst_n <= 1;
		rp_n <= 0;
		repeat (4) @(posedge clk_sys);
		cmp("mode", 8'h01, {7'h0, pm});
		for (int i = 0; i < 3; i++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			adr <= {1'b1, 6'(i), 8'($urandom)};
			rd(1'b0, 1'b0, 8'hff);
			wr(a);
			wr(b);
			rd(1'b1, 1'b1, a & b);
			rd(1'b0, 1'b0, a & b);
			pins(1'b0, 1'b1, 1'b0);
		end
		cmp("writes", 8'h06, 8'(writes_seen));
		final_report();
	end
endmodule : testbench
`default_nettype wire

// [hdl/ppp_map.svh]
// Constants for the PROM programming port.
// Assumes inclusion by the port package and module only.
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH
`define PPP_ADDR_W      15
`define PPP_DATA_W      8
`define PPP_ERASED_BYTE 8'hff
`define PPP_DATA_RST    8'h00
`define PPP_SYNC_RST    1'b1
`endif

// [hdl/ppp_pkg.sv]
// Types for the PROM programming port.
// Assumes ppp_map.svh is on the include path.
`default_nettype none
`include "ppp_map.svh"
package ppp_pkg;
	typedef enum logic [4:0] {
		PPP_READ     = 5'b00001,
		PPP_ODIS     = 5'b00010,
		PPP_PROG     = 5'b00100,
		PPP_VERIFY   = 5'b01000,
		PPP_PDIS     = 5'b10000
	} ppp_mode_e;
endpackage : ppp_pkg
`default_nettype wire

// [hdl/ppp_port.sv]
// PROM programming port: pin-mode decode, byte store, read-out and verify.
// Assumes all programmer pins are asynchronous to clk_sys and are synchronised here.
// Assumes the programmer holds address and data steady across a CE fall.
// The one-time array lives in this module and starts blank.
`default_nettype none
`include "ppp_map.svh"
module ppp_port
	import ppp_pkg::*;
#(
	parameter int ADDR_W = `PPP_ADDR_W,
	parameter int DATA_W = `PPP_DATA_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic              chip_reset_pin_n,
	input  wire logic              ce_pin_n,
	input  wire logic              oe_pin_n,
	input  wire logic              vpp_pin,
	input  wire logic [ADDR_W-1:0] addr_pin,
	input  wire logic [DATA_W-1:0] data_pin_i,
	output var  logic [DATA_W-1:0] data_pin_o,
	output var  logic              data_pin_oe,
	output var  logic              prom_mode,
	output var  logic              prog_busy
);

	localparam int DEPTH = 1 << ADDR_W;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers
	logic [ADDR_W+DATA_W+3:0] sync1_ff;
	logic [ADDR_W+DATA_W+3:0] sync2_ff;
	wire  [ADDR_W+DATA_W+3:0] pins_raw = {chip_reset_pin_n, ce_pin_n, oe_pin_n, vpp_pin, addr_pin, data_pin_i};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_ff <= {1'b1, 1'b1, 1'b1, 1'b0, {(ADDR_W+DATA_W){1'b0}}};
			sync2_ff <= {1'b1, 1'b1, 1'b1, 1'b0, {(ADDR_W+DATA_W){1'b0}}};
		end else if (clk_en) begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
		end
	end

	wire              s_reset_n = sync2_ff[ADDR_W+DATA_W+3];
	wire              s_ce_n    = sync2_ff[ADDR_W+DATA_W+2];
	wire              s_oe_n    = sync2_ff[ADDR_W+DATA_W+1];
	wire              s_vpp     = sync2_ff[ADDR_W+DATA_W];
	wire [ADDR_W-1:0] s_addr    = sync2_ff[ADDR_W+DATA_W-1:DATA_W];
	wire [DATA_W-1:0] s_data    = sync2_ff[DATA_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Pin code decode
	logic      in_mode;
	logic      ce_low;
	logic      oe_low;
	logic      vpp_high;
	logic      sel_read;
	logic      sel_read_hv;
	logic      sel_prog;
	logic      sel_verify;
	logic      sel_pdis;
	logic      sel_undef;
	logic      mode_drives;
	logic      mode_writes;
	ppp_mode_e mode;
	logic      mode_valid;

	assign in_mode = !s_reset_n;

	// Pin levels as seen after sync
	assign ce_low   = !s_ce_n;
	assign oe_low   = !s_oe_n;
	assign vpp_high = s_vpp;

	assign sel_read    = ce_low && oe_low && !vpp_high;
	// Read with Vpp high still reads
	assign sel_read_hv = ce_low && oe_low && vpp_high;
	assign sel_prog    = ce_low && !oe_low && vpp_high;
	assign sel_verify  = !ce_low && oe_low && vpp_high;
	assign sel_pdis    = !ce_low && !oe_low && vpp_high;
	// Undefined pin code, pins float
	assign sel_undef   = !ce_low && oe_low && !vpp_high;

	////////////////////////////////////////////////////////////////////////
	// Mode select
	assign mode_valid = in_mode && !sel_undef;
	// output disable and idle fall to ODIS
	assign mode = (sel_read || sel_read_hv) ? PPP_READ
	            : sel_prog                   ? PPP_PROG
	            : sel_verify                 ? PPP_VERIFY
	            : sel_pdis                   ? PPP_PDIS
	            :                              PPP_ODIS;

	assign mode_drives = (mode == PPP_READ) || (mode == PPP_VERIFY);
	assign mode_writes = (mode == PPP_PROG);

	////////////////////////////////////////////////////////////////////////
	// Write start on CE fall
	logic ce_n_prev_ff;
	logic nxt_ce_n_prev;
	logic ce_fall;
	logic write_now;

	// Previous CE level for edge detect
	assign nxt_ce_n_prev = s_ce_n;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ce_n_prev_ff <= `PPP_SYNC_RST;
		end else if (clk_en) begin
			ce_n_prev_ff <= nxt_ce_n_prev;
		end
	end

	assign ce_fall   = ce_n_prev_ff && !s_ce_n;
	assign write_now = in_mode && ce_fall && mode_writes;

	////////////////////////////////////////////////////////////////////////
	// PROM array, shipped blank
	logic [DATA_W-1:0] mem_ff [DEPTH];
	logic [DATA_W-1:0] rd_byte;

	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_ff[i] = `PPP_ERASED_BYTE;
		end
	end

	// Programming clears bits only, as in a real cell
	always_ff @(posedge clk_sys) begin
		if (clk_en && write_now) begin
			mem_ff[s_addr] <= mem_ff[s_addr] & s_data;
		end
	end

	// Read port, combinational from the array
	assign rd_byte = mem_ff[s_addr];

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	localparam logic [DATA_W-1:0] DATA_RST = DATA_W'(`PPP_DATA_RST);

	logic              drive;
	logic [DATA_W-1:0] nxt_data_o;
	logic              nxt_data_oe;
	logic              nxt_prom_mode;
	logic              nxt_prog_busy;

	assign drive = mode_valid && mode_drives;

	// Per-bit select of array byte or idle level
	for (genvar gi = 0; gi < DATA_W; gi++) begin : g_dbit
		assign nxt_data_o[gi] = drive ? rd_byte[gi] : DATA_RST[gi];
	end

	assign nxt_data_oe   = drive;
	assign nxt_prom_mode = in_mode;
	// Byte programmed this cycle
	assign nxt_prog_busy = write_now;

	////////////////////////////////////////////////////////////////////////
	// Data output register
	// byte on pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			data_pin_o <= DATA_RST;
		end else if (clk_en) begin
			data_pin_o <= nxt_data_o;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output enable register
	// float otherwise
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			data_pin_oe <= 1'b0;
		end else if (clk_en) begin
			data_pin_oe <= nxt_data_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode flag register
	// mode flag
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prom_mode <= 1'b0;
		end else if (clk_en) begin
			prom_mode <= nxt_prom_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write pulse register
	// one pulse per byte
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prog_busy <= 1'b0;
		end else if (clk_en) begin
			prog_busy <= nxt_prog_busy;
		end
	end

endmodule : ppp_port
`default_nettype wire
